//--- core/dio_cfg.svh
// Offsets, field positions, reset values and timing counts of the digital I/O image block.
`ifndef DIO_CFG_SVH
`define DIO_CFG_SVH

// APB register byte offsets.
`define DIO_OFS_CTRL      8'h00
`define DIO_OFS_OUT_IMAGE 8'h04
`define DIO_OFS_IN_STATUS 8'h08
`define DIO_OFS_IN_DATA   8'h0C
`define DIO_OFS_CFG       8'h10
`define DIO_OFS_WDOG      8'h14
`define DIO_OFS_IRQ_STAT  8'h18
`define DIO_OFS_IRQ_MASK  8'h1C
`define DIO_OFS_STATE     8'h20
`define DIO_OFS_USED      8'h24

// Status word bit positions.
`define DIO_ST_SHORT      0
`define DIO_ST_OVERLOAD   1
`define DIO_ST_SENSOR     4
`define DIO_ST_UNDERVOLT  5

// Configuration register field positions.
`define DIO_CFG_MODE_LSB  0
`define DIO_CFG_MODE_MSB  7
`define DIO_CFG_PAT_LSB   8
`define DIO_CFG_PAT_MSB   23

// Highest legal substitute behaviour code.
`define DIO_MODE_MAX      8'h03

// Interrupt event bit positions.
`define DIO_EV_SHORT      0
`define DIO_EV_OVERLOAD   1
`define DIO_EV_SENSOR     2
`define DIO_EV_UNDERVOLT  3
`define DIO_EV_TIMEOUT    4
`define DIO_EV_CONN_RDY   5
`define DIO_EV_CYC_RDY    6
`define DIO_EV_NUM        7

// Reset values.
`define DIO_RST_PATTERN   16'h0000
`define DIO_RST_IMAGE     16'h0000
`define DIO_RST_WDOG      32'h000F4240
`define DIO_RST_IRQ_MASK  7'h00

// Timing: clock rate and start-up times.
`define DIO_CLK_KHZ       100000
`define DIO_CONN_READY_MS 350
`define DIO_CYC_READY_MS  500

`endif

//--- core/dio_image_top.sv
// Process image core of the sixteen channel digital I/O module with its APB slave.
`timescale 1ns/1ps
`include "dio_cfg.svh"

// What this block does
// - Two-byte output image drives channels 1-16
// - Even bit pin 4, odd bit pin 2
// - Six-byte input image: status, then channels
// - Status bits: short, overload, sensor, undervoltage
// - Behaviour code selects zero, one, hold, pattern
// - Sixteen-bit substitute pattern, used in mode 3
// - Direction follows use of the output image
// - Output channel state echoed into input image
// - Connection ready 350 ms, cyclic 500 ms
// - Owner exchanges outputs; other kinds none
module dio_image_top #(
  parameter int unsigned CONN_READY_CYC = `DIO_CONN_READY_MS * `DIO_CLK_KHZ,
  parameter int unsigned CYC_READY_CYC  = `DIO_CYC_READY_MS * `DIO_CLK_KHZ
) (
  // Clock and reset.
  input  wire logic               core_clk,
  input  wire logic               rstn,
  // APB slave.
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Connector pins, index n is connector n+1.
  input  wire logic [7:0]         pin4In,
  input  wire logic [7:0]         pin2In,
  output logic      [7:0]         pin4Out,
  output logic      [7:0]         pin2Out,
  output logic      [7:0]         pin4Oe,
  output logic      [7:0]         pin2Oe,
  // Supply and output fault sense.
  input  wire logic               faultShort,
  input  wire logic               faultOverload,
  input  wire logic               faultSensor,
  input  wire logic               faultUndervolt,
  // Status and interrupt.
  output logic                    connReady,
  output logic                    cyclicReady,
  output logic                    irq
);
  import dio_pkg::*;

  //////////////////////////////////////////////////////////////////////////////////////
  // State.

  logic                  pready_r,      pready_nxt;
  logic [31:0]           prdata_r,      prdata_nxt;
  logic                  pslverr_r,     pslverr_nxt;
  dio_conn_e             connType_r,    connType_nxt;
  dio_image_t            outImage_r,    outImage_nxt;
  dio_image_t            usedMask_r,    usedMask_nxt;
  dio_subst_e            cfgMode_r,     cfgMode_nxt;
  dio_image_t            cfgPattern_r,  cfgPattern_nxt;
  logic [31:0]           wdogLimit_r,   wdogLimit_nxt;
  logic [31:0]           wdogCnt_r,     wdogCnt_nxt;
  logic                  outValid_r,    outValid_nxt;
  logic [`DIO_EV_NUM-1:0] irqStat_r,    irqStat_nxt;
  logic [`DIO_EV_NUM-1:0] irqMask_r,    irqMask_nxt;
  logic                  irq_r,         irq_nxt;
  logic [3:0]            faultPrev_r,   faultPrev_nxt;
  dio_pwr_e              pwrState_r,    pwrState_nxt;
  logic [31:0]           pwrCnt_r,      pwrCnt_nxt;
  dio_image_t            drive_r,       drive_nxt;
  dio_image_t            oe_r,          oe_nxt;
  dio_image_t            inImage_r,     inImage_nxt;
  logic [31:0]           status_r,      status_nxt;

  logic                  setupPh;
  logic                  accessWr;
  logic                  ownerOpen;
  logic                  outAccept;
  logic [3:0]            faultNow;
  logic [`DIO_EV_NUM-1:0] events;
  dio_image_t            chanIn;

  dio_subst_if           subBus ();

  //////////////////////////////////////////////////////////////////////////////////////
  // Pin to channel mapping.

  for (genvar c = 0; c < 8; c++) begin : g_conn
    assign chanIn[2*c]   = pin4In[c];
    assign chanIn[2*c+1] = pin2In[c];
    assign pin4Out[c]    = drive_r[2*c];
    assign pin2Out[c]    = drive_r[2*c+1];
    assign pin4Oe[c]     = oe_r[2*c];
    assign pin2Oe[c]     = oe_r[2*c+1];
  end

  //////////////////////////////////////////////////////////////////////////////////////
  // Bus decode helpers.

  // A write lands only at the access edge, when pready is seen high.
  assign setupPh   = psel & ~penable;
  assign accessWr  = psel & penable & pready_r & pwrite;
  assign ownerOpen = (connType_r == CONN_OWNER);
  assign outAccept = accessWr & (paddr == `DIO_OFS_OUT_IMAGE) & ownerOpen & cyclicReady;
  assign faultNow  = {faultUndervolt, faultSensor, faultOverload, faultShort};

  //////////////////////////////////////////////////////////////////////////////////////
  // Substitute selection.

  assign subBus.valid   = outValid_r;
  assign subBus.mode    = cfgMode_r;
  assign subBus.image   = outImage_r;
  assign subBus.pattern = cfgPattern_r;

  dio_subst_sel u_subst (
    .sub (subBus.sel)
  );

  //////////////////////////////////////////////////////////////////////////////////////
  // Start-up timing.

  always_comb begin
    pwrState_nxt = pwrState_r;
    pwrCnt_nxt   = pwrCnt_r;
    unique case (pwrState_r)
      PWR_BOOT: begin
        pwrCnt_nxt = pwrCnt_r + 32'h00000001;
        if (pwrCnt_r >= CONN_READY_CYC - 1) begin
          pwrState_nxt = PWR_CONN;
        end
      end
      PWR_CONN: begin
        pwrCnt_nxt = pwrCnt_r + 32'h00000001;
        if (pwrCnt_r >= CYC_READY_CYC - 1) begin
          pwrState_nxt = PWR_RUN;
        end
      end
      PWR_RUN: begin
        pwrCnt_nxt = pwrCnt_r;
      end
      default: begin
        pwrState_nxt = PWR_BOOT;
        pwrCnt_nxt   = 32'h00000000;
      end
    endcase
  end

  // Start-up registers.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pwrState_r <= PWR_BOOT;
      pwrCnt_r   <= 32'h00000000;
    end else begin
      pwrState_r <= pwrState_nxt;
      pwrCnt_r   <= pwrCnt_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////
  // Connection, image, watchdog and channel drive.

  always_comb begin
    connType_nxt   = connType_r;
    outImage_nxt   = outImage_r;
    usedMask_nxt   = usedMask_r;
    cfgMode_nxt    = cfgMode_r;
    cfgPattern_nxt = cfgPattern_r;
    wdogLimit_nxt  = wdogLimit_r;
    wdogCnt_nxt    = wdogCnt_r;
    outValid_nxt   = outValid_r;

    // Connections may be opened only once the device is ready for them.
    if (accessWr && paddr == `DIO_OFS_CTRL && pwrState_r != PWR_BOOT) begin
      connType_nxt = dio_conn_e'(pwdata[1:0]);
    end
    // Listen-only connections carry no configuration image.
    if (accessWr && paddr == `DIO_OFS_CFG && connType_r != CONN_LISTEN) begin
      if (pwdata[`DIO_CFG_MODE_MSB:`DIO_CFG_MODE_LSB] <= `DIO_MODE_MAX) begin
        cfgMode_nxt = dio_subst_e'(pwdata[1:0]);
      end
      cfgPattern_nxt = pwdata[`DIO_CFG_PAT_MSB:`DIO_CFG_PAT_LSB];
    end
    if (accessWr && paddr == `DIO_OFS_WDOG) begin
      wdogLimit_nxt = pwdata;
    end

    if (outAccept) begin
      outImage_nxt = pwdata[15:0];
      usedMask_nxt = usedMask_r | pwdata[15:0];
      wdogCnt_nxt  = 32'h00000000;
      outValid_nxt = 1'b1;
    end else if (outValid_r) begin
      wdogCnt_nxt = wdogCnt_r + 32'h00000001;
      // A limit of zero disables the watchdog.
      if (wdogLimit_r != 32'h00000000 && wdogCnt_r >= wdogLimit_r - 32'h00000001) begin
        outValid_nxt = 1'b0;
      end
    end

    // Closing the owner connection releases every output channel.
    if (connType_nxt != CONN_OWNER) begin
      outValid_nxt = 1'b0;
      usedMask_nxt = 16'h0000;
    end
  end

  // Channel drive, status word and echoed input image.
  always_comb begin
    drive_nxt  = subBus.result & usedMask_r;
    oe_nxt     = usedMask_r;
    status_nxt = 32'h00000000;
    status_nxt[`DIO_ST_SHORT]     = faultShort;
    status_nxt[`DIO_ST_OVERLOAD]  = faultOverload;
    status_nxt[`DIO_ST_SENSOR]    = faultSensor;
    status_nxt[`DIO_ST_UNDERVOLT] = faultUndervolt;
    inImage_nxt = (drive_r & oe_r) | (chanIn & ~oe_r);
  end

  // Image registers. Pins are driven only for used channels, so an
  // input channel is never fought by the module.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      connType_r   <= CONN_NONE;
      outImage_r   <= `DIO_RST_IMAGE;
      usedMask_r   <= 16'h0000;
      cfgMode_r    <= SUBST_ZERO;
      cfgPattern_r <= `DIO_RST_PATTERN;
      wdogLimit_r  <= `DIO_RST_WDOG;
      wdogCnt_r    <= 32'h00000000;
      outValid_r   <= 1'b0;
      drive_r      <= 16'h0000;
      oe_r         <= 16'h0000;
      status_r     <= 32'h00000000;
      inImage_r    <= 16'h0000;
    end else begin
      connType_r   <= connType_nxt;
      outImage_r   <= outImage_nxt;
      usedMask_r   <= usedMask_nxt;
      cfgMode_r    <= cfgMode_nxt;
      cfgPattern_r <= cfgPattern_nxt;
      wdogLimit_r  <= wdogLimit_nxt;
      wdogCnt_r    <= wdogCnt_nxt;
      outValid_r   <= outValid_nxt;
      drive_r      <= drive_nxt;
      oe_r         <= oe_nxt;
      status_r     <= status_nxt;
      inImage_r    <= inImage_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////
  // Interrupts.

  always_comb begin
    events                         = '0;
    events[`DIO_EV_SHORT]          = faultShort & ~faultPrev_r[0];
    events[`DIO_EV_OVERLOAD]       = faultOverload & ~faultPrev_r[1];
    events[`DIO_EV_SENSOR]         = faultSensor & ~faultPrev_r[2];
    events[`DIO_EV_UNDERVOLT]      = faultUndervolt & ~faultPrev_r[3];
    // Closing the owner connection is not a timeout, so it raises no event.
    events[`DIO_EV_TIMEOUT]        = outValid_r & ~outValid_nxt & (connType_nxt == CONN_OWNER);
    events[`DIO_EV_CONN_RDY]       = (pwrState_r == PWR_BOOT) & (pwrState_nxt == PWR_CONN);
    events[`DIO_EV_CYC_RDY]        = (pwrState_r == PWR_CONN) & (pwrState_nxt == PWR_RUN);
    faultPrev_nxt                  = faultNow;
    irqMask_nxt                    = irqMask_r;
    irqStat_nxt                    = irqStat_r;
    if (accessWr && paddr == `DIO_OFS_IRQ_MASK) begin
      irqMask_nxt = pwdata[`DIO_EV_NUM-1:0];
    end
    if (accessWr && paddr == `DIO_OFS_IRQ_STAT) begin
      irqStat_nxt = irqStat_r & ~pwdata[`DIO_EV_NUM-1:0];
    end
    // A new event wins over a clear in the same cycle.
    irqStat_nxt = irqStat_nxt | events;
    irq_nxt     = |(irqStat_nxt & irqMask_nxt);
  end

  // Interrupt registers.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      irqStat_r   <= '0;
      irqMask_r   <= `DIO_RST_IRQ_MASK;
      irq_r       <= 1'b0;
      faultPrev_r <= 4'h0;
    end else begin
      irqStat_r   <= irqStat_nxt;
      irqMask_r   <= irqMask_nxt;
      irq_r       <= irq_nxt;
      faultPrev_r <= faultPrev_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////
  // APB read path; read data is captured in the setup cycle.

  always_comb begin
    pready_nxt  = setupPh;
    prdata_nxt  = prdata_r;
    pslverr_nxt = 1'b0;
    if (setupPh) begin
      prdata_nxt = 32'h00000000;
      unique case (paddr)
        `DIO_OFS_CTRL:      prdata_nxt[1:0] = connType_r;
        `DIO_OFS_OUT_IMAGE: prdata_nxt[15:0] = outImage_r;
        `DIO_OFS_IN_STATUS: prdata_nxt = status_r;
        `DIO_OFS_IN_DATA:   prdata_nxt[15:0] = inImage_r;
        `DIO_OFS_CFG: begin
          prdata_nxt[1:0] = cfgMode_r;
          prdata_nxt[`DIO_CFG_PAT_MSB:`DIO_CFG_PAT_LSB] = cfgPattern_r;
        end
        `DIO_OFS_WDOG:      prdata_nxt = wdogLimit_r;
        `DIO_OFS_IRQ_STAT:  prdata_nxt[`DIO_EV_NUM-1:0] = irqStat_r;
        `DIO_OFS_IRQ_MASK:  prdata_nxt[`DIO_EV_NUM-1:0] = irqMask_r;
        `DIO_OFS_STATE:     prdata_nxt[2:0] = {outValid_r, cyclicReady, connReady};
        `DIO_OFS_USED:      prdata_nxt[15:0] = usedMask_r;
        default:            pslverr_nxt = 1'b1;
      endcase
    end
  end

  // Bus registers and ready flags.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pready_r    <= 1'b0;
      prdata_r    <= 32'h00000000;
      pslverr_r   <= 1'b0;
      connReady   <= 1'b0;
      cyclicReady <= 1'b0;
    end else begin
      pready_r    <= pready_nxt;
      prdata_r    <= prdata_nxt;
      pslverr_r   <= pslverr_nxt;
      connReady   <= (pwrState_nxt != PWR_BOOT);
      cyclicReady <= (pwrState_nxt == PWR_RUN);
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign irq     = irq_r;

endmodule : dio_image_top

//--- core/dio_pkg.sv
// Types shared by the digital I/O image block.
package dio_pkg;

  // Substitute behaviour, encoded 0 to 3 in declaration order.
  typedef enum logic [1:0] {
    SUBST_ZERO,
    SUBST_ONE,
    SUBST_HOLD,
    SUBST_PATTERN
  } dio_subst_e;

  // Connection kind opened by the scanner.
  typedef enum logic [1:0] {
    CONN_NONE,
    CONN_OWNER,
    CONN_INONLY,
    CONN_LISTEN
  } dio_conn_e;

  // Start-up progress after power is applied.
  typedef enum logic [1:0] {
    PWR_BOOT,
    PWR_CONN,
    PWR_RUN
  } dio_pwr_e;

  typedef logic [15:0] dio_image_t;

endpackage : dio_pkg

//--- core/dio_subst_if.sv
// Interface between the image core and the substitute value selector.
`timescale 1ns/1ps
interface dio_subst_if;
  import dio_pkg::*;
  logic               valid;
  dio_subst_e         mode;
  dio_image_t         image;
  dio_image_t         pattern;
  dio_image_t         result;

  modport ctl (output valid, output mode, output image, output pattern, input result);
  modport sel (input valid, input mode, input image, input pattern, output result);
endinterface : dio_subst_if

//--- core/dio_subst_sel.sv
// Selects the output image or its substitute value.
`timescale 1ns/1ps
module dio_subst_sel (
  // Selection request and answer.
  dio_subst_if.sel sub
);
  import dio_pkg::*;

  // Valid data passes through; otherwise the configured behaviour applies.
  always_comb begin
    sub.result = sub.image;
    if (!sub.valid) begin
      unique case (sub.mode)
        SUBST_ZERO:    sub.result = 16'h0000;
        SUBST_ONE:     sub.result = 16'hFFFF;
        SUBST_HOLD:    sub.result = sub.image;
        SUBST_PATTERN: sub.result = sub.pattern;
      endcase
    end
  end

endmodule : dio_subst_sel

//--- tb/dio16_process_image_tb.sv
// Self-checking bench for the process image block.
`timescale 1ns/1ps
`include "dio_cfg.svh"
module dio16_process_image_tb;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, rerr, irq, connReady, cyclicReady;
  logic [7:0]  paddr, pin4In, pin2In, pin4Out, pin2Out, pin4Oe, pin2Oe;
  logic [31:0] pwdata, prdata, rdata;
  logic        fShort, fOver, fSens, fUnder;
  logic [15:0] sensor;
  logic [15:0] subst [4] = '{16'h0000, 16'h8001, 16'h0001, 16'h8000};
  int          mismatches = 0;
  int          comparisons = 0;
  int          n;

  // Free-running core clock.
  always #5 core_clk = ~core_clk;

  dio_image_top #(.CONN_READY_CYC(20), .CYC_READY_CYC(40)) dut (
    .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin4In(pin4In), .pin2In(pin2In), .pin4Out(pin4Out), .pin2Out(pin2Out),
    .pin4Oe(pin4Oe), .pin2Oe(pin2Oe), .faultShort(fShort), .faultOverload(fOver),
    .faultSensor(fSens), .faultUndervolt(fUnder), .connReady(connReady),
    .cyclicReady(cyclicReady), .irq(irq));

  dio_field_model field (.pin4Out(pin4Out), .pin2Out(pin2Out), .pin4Oe(pin4Oe),
    .pin2Oe(pin2Oe), .sensor(sensor), .pin4In(pin4In), .pin2In(pin2In));

  ////////////////////////////////////////////////////////////////////////////////
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One APB transfer; an idle edge first so no strobe is assigned twice in a step.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) mismatches++;
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    check(what, rdata, exp);
  endtask : rd

  function automatic logic [7:0] ev(input logic [15:0] v, input int odd);
    for (int i = 0; i < 8; i++) ev[i] = v[2*i+odd];
  endfunction : ev

  // Compares drive levels and enables of both pins of every connector.
  task pins(input logic [15:0] drv, input logic [15:0] oe);
    check("pin4Out", 32'(pin4Out), 32'(ev(drv, 0)));
    check("pin2Out", 32'(pin2Out), 32'(ev(drv, 1)));
    check("pin4Oe", 32'(pin4Oe), 32'(ev(oe, 0)));
    check("pin2Oe", 32'(pin2Oe), 32'(ev(oe, 1)));
  endtask : pins

  task finish_test;
    if (mismatches == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence; the owner connection writes ones only to channels 1 and 16.
  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    fShort = 1'b0; fOver = 1'b0; fSens = 1'b0; fUnder = 1'b0;
    // sensor channels are never written as outputs.
    sensor = 16'h3C5A;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    wr(`DIO_OFS_CTRL, 32'h1);
    rd(`DIO_OFS_CTRL, 32'h0, "ctrl early");
    check("connReady early", 32'(connReady), 32'h0);
    n = 0;
    while (cyclicReady !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    check("cyclicReady", 32'(cyclicReady), 32'h1);
    rd(`DIO_OFS_STATE, 32'h3, "state");
    wr(`DIO_OFS_CTRL, 32'h1);
    wr(`DIO_OFS_WDOG, 32'd30);
    wr(`DIO_OFS_OUT_IMAGE, 32'h8001);
    repeat (3) @(posedge core_clk);
    pins(16'h8001, 16'h8001);
    rd(`DIO_OFS_IN_DATA, 32'hBC5B, "in data");
    wr(`DIO_OFS_OUT_IMAGE, 32'h0001);
    repeat (3) @(posedge core_clk);
    pins(16'h0001, 16'h8001);
    rd(`DIO_OFS_IN_DATA, 32'h3C5B, "in data low");
    rd(`DIO_OFS_USED, 32'h8001, "used mask");
    for (int m = 0; m < 4; m++) begin
      wr(`DIO_OFS_CFG, {8'h00, 16'h8000, 8'(m)});
      wr(`DIO_OFS_OUT_IMAGE, 32'h0001);
      repeat (45) @(posedge core_clk);
      pins(subst[m], 16'h8001);
    end
    wr(`DIO_OFS_CFG, 32'h4);
    rd(`DIO_OFS_CFG, 32'h3, "cfg bad mode");
    rd(`DIO_OFS_IRQ_STAT, 32'h70, "irq stat");
    {fShort, fOver, fSens, fUnder} <= 4'hF;
    repeat (3) @(posedge core_clk);
    rd(`DIO_OFS_IN_STATUS, 32'h33, "status");
    check("irq masked", 32'(irq), 32'h0);
    wr(`DIO_OFS_IRQ_MASK, 32'h01);
    repeat (2) @(posedge core_clk);
    check("irq", 32'(irq), 32'h1);
    {fShort, fOver, fSens, fUnder} <= 4'h0;
    wr(`DIO_OFS_IRQ_STAT, 32'h7F);
    repeat (2) @(posedge core_clk);
    check("irq cleared", 32'(irq), 32'h0);
    // Outputs are released and no longer valid when the owner connection is closed.
    wr(`DIO_OFS_OUT_IMAGE, 32'h0001);
    wr(`DIO_OFS_CTRL, 32'h2);
    wr(`DIO_OFS_OUT_IMAGE, 32'hFFFF);
    repeat (3) @(posedge core_clk);
    pins(16'h0000, 16'h0000);
    rd(`DIO_OFS_IRQ_STAT, 32'h0, "no timeout on close");
    // A listen-only connection refuses the configuration image.
    wr(`DIO_OFS_CTRL, 32'h3);
    wr(`DIO_OFS_CFG, 32'h00000101);
    rd(`DIO_OFS_CFG, 32'h3, "cfg listen");
    rd(8'h40, 32'h0, "unmapped");
    check("slverr", 32'(rerr), 32'h1);
    finish_test();
  end

  // Watchdog against a hung handshake.
  initial begin
    #50000;
    mismatches++;
    finish_test();
  end
endmodule : dio16_process_image_tb

bind dio_image_top dio_image_sva #(
  .CONN_READY_CYC(CONN_READY_CYC), .CYC_READY_CYC(CYC_READY_CYC)) u_sva (
  .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin4Out(pin4Out),
  .pin2Out(pin2Out), .pin4Oe(pin4Oe), .pin2Oe(pin2Oe), .connReady(connReady),
  .cyclicReady(cyclicReady), .irq(irq));

//--- tb/dio_field_model.sv
// Field wiring model: sensors on input channels, read-back on driven ones.
`timescale 1ns/1ps
module dio_field_model (
  // Module drive.
  input  wire logic [7:0]  pin4Out,
  input  wire logic [7:0]  pin2Out,
  input  wire logic [7:0]  pin4Oe,
  input  wire logic [7:0]  pin2Oe,
  // Sensor levels, bit k is channel k+1.
  input  wire logic [15:0] sensor,
  // Levels seen by the module.
  output logic      [7:0]  pin4In,
  output logic      [7:0]  pin2In
);
  // driven pin reads back: a driven line shows the module level, else the sensor.
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      pin4In[n] = pin4Oe[n] ? pin4Out[n] : sensor[2*n];
      pin2In[n] = pin2Oe[n] ? pin2Out[n] : sensor[2*n+1];
    end
  end
endmodule : dio_field_model

//--- tb/dio_image_sva.sv
// Concurrent checks on the ports of the process image block.
`timescale 1ns/1ps
module dio_image_sva #(
  parameter int unsigned CONN_READY_CYC = 20,
  parameter int unsigned CYC_READY_CYC  = 40
) (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // APB slave side.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // Connector drive.
  input  wire logic [7:0]  pin4Out,
  input  wire logic [7:0]  pin2Out,
  input  wire logic [7:0]  pin4Oe,
  input  wire logic [7:0]  pin2Oe,
  // Status.
  input  wire logic        connReady,
  input  wire logic        cyclicReady,
  input  wire logic        irq
);
  logic [31:0] upCnt_r;
  logic [31:0] upCnt_nxt;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // Cycles since reset release; saturates so a long run cannot wrap it.
  always_comb begin
    upCnt_nxt = !rstn ? 32'h0 : (&upCnt_r ? upCnt_r : upCnt_r + 32'h1);
  end
  always_ff @(posedge core_clk) begin
    upCnt_r <= upCnt_nxt;
  end

  a_setup_answer: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_unmapped_err: assert property (psel && !penable && paddr > 8'h24 |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_conn_early: assert property (upCnt_r + 2 < CONN_READY_CYC |-> !connReady)
    else $error("connReady too early");
  a_conn_late: assert property (upCnt_r > CONN_READY_CYC + 1 |-> connReady)
    else $error("connReady too late");
  a_cyc_early: assert property (upCnt_r + 2 < CYC_READY_CYC |-> !cyclicReady)
    else $error("cyclicReady too early");
  a_cyc_late: assert property (upCnt_r > CYC_READY_CYC + 1 |-> cyclicReady)
    else $error("cyclicReady too late");
  a_undriven_low: assert property (((pin4Out & ~pin4Oe) | (pin2Out & ~pin2Oe)) == 8'h00)
    else $error("level on an undriven channel");

  c_cyclic: cover property ($rose(cyclicReady));
  c_refused: cover property (pslverr);
  c_irq: cover property ($rose(irq));
  c_drive_hi: cover property (|pin2Oe);
endmodule : dio_image_sva
